// ==== lcdi_pkg.sv ====
// Shared constants and types for the character display instruction decoder.
// Assumes one 10 MHz clock shared by both ends of the parallel link.
package lcdi_pkg;
	// ------------------------------------------------------------------
	// Clock and execution times
	// ------------------------------------------------------------------
	localparam int CLK_NS      = 100;
	localparam int T_SHORT_NS  = 26300;
	localparam int T_LONG_NS   = 1080000;
	localparam int T_BLINK_NS  = 400000000;
	localparam int SHORT_CYC   = (T_SHORT_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_CYC    = (T_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int BLINK_CYC   = T_BLINK_NS / CLK_NS;
	localparam int E_CYC       = 2;
	localparam int GAP_CYC     = 2;
	// ------------------------------------------------------------------
	// Memory sizes and address limits
	// ------------------------------------------------------------------
	localparam int DD_SIZE     = 128;
	localparam int CG_SIZE     = 64;
	localparam int ICON_SIZE   = 16;
	localparam logic [6:0] DD_LINE1_END = 7'h27;
	localparam logic [6:0] DD_LINE2_BEG = 7'h40;
	localparam logic [6:0] DD_LINE2_END = 7'h67;
	localparam logic [6:0] DD_ONE_END   = 7'h4F;
	localparam logic [6:0] LINE_LEN     = 7'h28;
	localparam logic [6:0] ONE_LEN      = 7'h50;
	localparam logic [7:0] SPACE_CODE   = 8'h20;
	localparam logic [7:0] ALL_DOTS     = 8'hFF;
	// ------------------------------------------------------------------
	// Instruction field positions
	// ------------------------------------------------------------------
	localparam int FS_WIDE = 4;
	localparam int FS_ROWS = 3;
	localparam int FS_TALL = 2;
	localparam int FS_EXT  = 0;
	localparam int DC_PIC  = 2;
	localparam int DC_CUR  = 1;
	localparam int DC_FLSH = 0;
	localparam int EM_UP   = 1;
	localparam int EM_PAN  = 0;
	localparam int SH_SC   = 3;
	localparam int SH_RL   = 2;
	localparam int OSC_BS  = 3;
	// ------------------------------------------------------------------
	// Controller register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam logic [3:0] REG_CMD   = 4'h0;
	localparam logic [3:0] REG_CTRL  = 4'h4;
	localparam logic [3:0] REG_STAT  = 4'h8;
	localparam logic [3:0] REG_RDATA = 4'hC;
	localparam int CMD_RS  = 8;
	localparam int CMD_RD  = 9;
	localparam int CTL_WIDE = 0;
	localparam logic CTL_WIDE_RST = 1'b1;
	typedef enum logic [1:0] {RAM_DD, RAM_CG, RAM_ICON} lcdi_ram_t;
endpackage : lcdi_pkg

// ==== lcdi_bus_if.sv ====
// Parallel host link between the controller end and the display end.
// Assumes both ends run on mclk; the data wire is resolved here from enables.
`timescale 1ns/1ps
interface lcdi_bus_if;
	logic       register_select;
	logic       read_not_write;
	logic       enable;
	logic [7:0] host_data;
	logic       host_data_oe_n;
	logic [7:0] dev_data;
	logic       dev_data_oe_n;
	logic [7:0] data_bus;

	// Wire level: host drive, else device drive, else pulled high
	assign data_bus = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 8'hFF);

	modport ctrl (output register_select, output read_not_write, output enable,
		output host_data, output host_data_oe_n, input data_bus);
	modport lcd (input register_select, input read_not_write, input enable,
		output dev_data, output dev_data_oe_n, input data_bus);
endinterface : lcdi_bus_if

// ==== lcdi_device.sv ====
// Display end: instruction decoder, address counter, display RAMs, scan port.
// Assumes the controller end keeps to the enable timing and polls the flag.
`timescale 1ns/1ps
module lcdi_device #(
	parameter int LONG_CYC  = lcdi_pkg::LONG_CYC,
	parameter int BLINK_CYC = lcdi_pkg::BLINK_CYC
) (
	input  wire logic      mclk,
	input  wire logic      rst_b,
	lcdi_bus_if.lcd        bus,
	input  wire logic      alternate_set_pin,
	input  wire logic      bias_source_sel_1,
	input  wire logic      bias_source_sel_2,
	input  wire logic      scan_row,
	input  wire logic [6:0] scan_col,
	output logic     [7:0] scan_char,
	output logic           scan_cursor,
	output logic           picture_on,
	output logic           tall_font,
	output logic           two_row,
	output logic           bias_quarter
);
	import lcdi_pkg::*;

	localparam int BW = $clog2(LONG_CYC + 1);
	localparam int KW = $clog2(BLINK_CYC + 1);
	generate
		if (LONG_CYC < SHORT_CYC || LONG_CYC < DD_SIZE || BLINK_CYC < 2) begin : g_chk
			$error("lcdi_device: timing parameters too small");
		end
	endgenerate

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]  dd_mem [DD_SIZE];
	logic [7:0]  cg_mem [CG_SIZE];
	logic [7:0]  icon_mem [ICON_SIZE];
	logic [6:0]  ac;
	lcdi_ram_t   ram_sel;
	logic        step_up, view_pan_on_write, marker_shown, marker_flash;
	logic        wide_port, tall_glyph, extended_table, one_quarter_bias;
	logic [6:0]  shift_ofs;
	logic [7:0]  read_buf;
	logic [BW-1:0] busy_cnt;
	logic        clr_act;
	logic [6:0]  clr_idx;
	logic [KW-1:0] blink_cnt;
	logic        blink_ph;
	logic        e_q, half;
	logic [3:0]  hi_nib;
	logic [2:0]  pin_s1, pin_s2;

	// Strap and bias pins pass two flip-flops
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else begin
			pin_s1 <= {alternate_set_pin, bias_source_sel_1, bias_source_sel_2};
			pin_s2 <= pin_s1;
		end
	end
	wire alt_set = pin_s2[2];
	wire ext_bias = pin_s2[1] & pin_s2[0];

	// ------------------------------------------------------------------
	// Link byte assembly
	// ------------------------------------------------------------------
	wire working_flag = (busy_cnt != '0);
	wire take = bus.enable & ~e_q;
	wire byte_done = take & (wide_port | half);
	wire [7:0] wr_byte = wide_port ? bus.data_bus : {hi_nib, bus.data_bus[7:4]};
	wire is_rd = bus.read_not_write;
	wire is_rs = bus.register_select;
	wire cmd = byte_done & ~is_rd & ~is_rs & ~working_flag;
	wire dwr = byte_done & ~is_rd & is_rs & ~working_flag;
	wire drd = byte_done & is_rd & is_rs & ~working_flag;
	wire [7:0] rbyte = is_rs ? read_buf : {working_flag, ac};

	// Strobe edge and nibble half tracking
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			e_q <= 1'b0;
			half <= 1'b0;
			hi_nib <= 4'h0;
		end else begin
			e_q <= bus.enable;
			if (take && !wide_port) begin
				half <= ~half;
				hi_nib <= bus.data_bus[7:4];
			end else if (wide_port) begin
				half <= 1'b0;
			end
		end
	end

	// Read answer register and drive enable
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bus.dev_data <= 8'h00;
		end else if (take && is_rd) begin
			if (wide_port) begin
				bus.dev_data <= rbyte;
			end else begin
				bus.dev_data <= half ? {rbyte[3:0], 4'h0} : {rbyte[7:4], 4'h0};
			end
		end
	end
	assign bus.dev_data_oe_n = ~(bus.enable & is_rd);

	// ------------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------------
	// table select, unavailable with strap high
	wire ext_eff = extended_table & ~alt_set;
	wire i_clear = cmd && wr_byte == 8'h01;
	wire i_home  = cmd && wr_byte[7:1] == 7'h01;
	wire i_entry = cmd && wr_byte[7:2] == 6'h01;
	wire i_onoff = cmd && wr_byte[7:3] == 5'h01;
	wire i_shift = cmd && wr_byte[7:4] == 4'h1 && !ext_eff;
	wire i_bias  = cmd && wr_byte[7:4] == 4'h1 && ext_eff;
	wire i_func  = cmd && wr_byte[7:5] == 3'h1;
	wire i_cgset = cmd && wr_byte[7:6] == 2'h1 && !ext_eff;
	wire i_icset = cmd && wr_byte[7:4] == 4'h4 && ext_eff;
	wire i_ddset = cmd && wr_byte[7];
	wire addr_set = i_cgset | i_icset | i_ddset;

	// display address stepping with line wrap
	function automatic logic [6:0] step_dd(input logic [6:0] a, input logic up,
		input logic two, input logic tall);
		logic [6:0] top;
		top = (two || tall) ? DD_LINE1_END : DD_ONE_END;
		if (two) begin
			if (up) begin
				step_dd = (a == DD_LINE1_END) ? DD_LINE2_BEG :
					((a == DD_LINE2_END) ? 7'h00 : a + 7'h01);
			end else begin
				step_dd = (a == 7'h00) ? DD_LINE2_END :
					((a == DD_LINE2_BEG) ? DD_LINE1_END : a - 7'h01);
			end
		end else if (up) begin
			step_dd = (a >= top) ? 7'h00 : a + 7'h01;
		end else begin
			step_dd = (a == 7'h00) ? top : a - 7'h01;
		end
	endfunction : step_dd

	function automatic logic [6:0] step_any(input logic [6:0] a, input logic up,
		input lcdi_ram_t sel, input logic two, input logic tall);
		logic [5:0] c;
		logic [3:0] s;
		c = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
		s = up ? a[3:0] + 4'h1 : a[3:0] - 4'h1;
		case (sel)
			RAM_CG:   step_any = {1'b0, c};
			RAM_ICON: step_any = {3'h0, s};
			default:  step_any = step_dd(a, up, two, tall);
		endcase
	endfunction : step_any

	// Mode bits
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			step_up <= 1'b1;
			view_pan_on_write <= 1'b0;
			picture_on <= 1'b0;
			marker_shown <= 1'b0;
			marker_flash <= 1'b0;
			wide_port <= CTL_WIDE_RST;
			two_row <= 1'b0;
			tall_glyph <= 1'b0;
			extended_table <= 1'b0;
			one_quarter_bias <= 1'b0;
		end else begin
			if (i_clear) begin
				step_up <= 1'b1;
			end else if (i_entry) begin
				step_up <= wr_byte[EM_UP];
				view_pan_on_write <= wr_byte[EM_PAN];
			end
			if (i_onoff) begin
				picture_on <= wr_byte[DC_PIC];
				marker_shown <= wr_byte[DC_CUR];
				marker_flash <= wr_byte[DC_FLSH];
			end
			if (i_func) begin
				wide_port <= wr_byte[FS_WIDE];
				two_row <= wr_byte[FS_ROWS];
				tall_glyph <= wr_byte[FS_TALL];
				extended_table <= wr_byte[FS_EXT];
			end
			if (i_bias) begin
				one_quarter_bias <= wr_byte[OSC_BS];
			end
		end
	end

	// tall glyphs only with strap low and one line
	assign tall_font = tall_glyph & ~two_row & ~alt_set;
	assign bias_quarter = one_quarter_bias & ~ext_bias;

	// Address counter and RAM selection
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ac <= 7'h00;
			ram_sel <= RAM_DD;
		end else if (i_clear || i_home) begin
			ac <= 7'h00;
			ram_sel <= RAM_DD;
		end else if (i_ddset) begin
			ac <= wr_byte[6:0];
			ram_sel <= RAM_DD;
		end else if (i_cgset) begin
			ac <= {1'b0, wr_byte[5:0]};
			ram_sel <= RAM_CG;
		end else if (i_icset) begin
			ac <= {3'h0, wr_byte[3:0]};
			ram_sel <= RAM_ICON;
		end else if (i_shift && !wr_byte[SH_SC]) begin
			ac <= step_dd(ac, wr_byte[SH_RL], two_row, tall_font);
		end else if (dwr || drd) begin
			ac <= step_any(ac, step_up, ram_sel, two_row, tall_font);
		end
	end

	wire pan = dwr && view_pan_on_write && ram_sel == RAM_DD;
	wire sh_disp = i_shift && wr_byte[SH_SC];
	wire sh_left = pan ? step_up : ~wr_byte[SH_RL];
	wire [6:0] line_len = (two_row || tall_font) ? LINE_LEN : ONE_LEN;
	always_ff @(posedge mclk) begin
		if (!rst_b || i_clear || i_home) begin
			shift_ofs <= 7'h00;
		end else if (pan || sh_disp) begin
			if (sh_left) begin
				shift_ofs <= (shift_ofs >= line_len - 7'h01) ? 7'h00 : shift_ofs + 7'h01;
			end else begin
				shift_ofs <= (shift_ofs == 7'h00) ? line_len - 7'h01 : shift_ofs - 7'h01;
			end
		end
	end

	// data write to selected RAM; clear fills spaces
	always_ff @(posedge mclk) begin
		if (clr_act) begin
			dd_mem[clr_idx] <= SPACE_CODE;
		end else if (dwr) begin
			case (ram_sel)
				RAM_CG:   cg_mem[ac[5:0]] <= wr_byte;
				RAM_ICON: icon_mem[ac[3:0]] <= wr_byte;
				default:  dd_mem[ac] <= wr_byte;
			endcase
		end
	end

	// prefetch only on address set and read
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			read_buf <= 8'h00;
		end else if (addr_set || drd) begin
			case (i_cgset ? RAM_CG : (i_icset ? RAM_ICON : (i_ddset ? RAM_DD : ram_sel)))
				RAM_CG:   read_buf <= cg_mem[i_cgset ? wr_byte[5:0] :
					(step_up ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01)];
				RAM_ICON: read_buf <= icon_mem[i_icset ? wr_byte[3:0] :
					(step_up ? ac[3:0] + 4'h1 : ac[3:0] - 4'h1)];
				default:  read_buf <= dd_mem[i_ddset ? wr_byte[6:0] :
					step_dd(ac, step_up, two_row, tall_font)];
			endcase
		end
	end

	// working flag timer and clear sweep
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			busy_cnt <= '0;
			clr_act <= 1'b0;
			clr_idx <= 7'h00;
		end else if (i_clear || i_home) begin
			busy_cnt <= BW'(LONG_CYC);
			clr_act <= i_clear;
			clr_idx <= 7'h00;
		end else if (cmd || dwr || drd) begin
			busy_cnt <= BW'(SHORT_CYC);
		end else begin
			if (working_flag) begin
				busy_cnt <= busy_cnt - BW'(1);
			end
			if (clr_act) begin
				clr_idx <= clr_idx + 7'h01;
				clr_act <= (clr_idx != 7'(DD_SIZE - 1));
			end
		end
	end

	// ------------------------------------------------------------------
	// Scan port with cursor overlay
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b || blink_cnt == KW'(BLINK_CYC - 1)) begin
			blink_cnt <= '0;
			blink_ph <= rst_b & ~blink_ph;
		end else begin
			blink_cnt <= blink_cnt + KW'(1);
		end
	end

	wire [7:0] pos_sum = {1'b0, scan_col} + {1'b0, shift_ofs};
	wire [7:0] pos_w = (pos_sum >= {1'b0, line_len}) ? pos_sum - {1'b0, line_len} : pos_sum;
	wire [6:0] scan_addr = pos_w[6:0] | ((scan_row && two_row) ? DD_LINE2_BEG : 7'h00);
	wire at_cur = (scan_addr == ac) && ram_sel == RAM_DD;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			scan_char <= SPACE_CODE;
			scan_cursor <= 1'b0;
		end else if (!picture_on) begin
			scan_char <= SPACE_CODE;
			scan_cursor <= 1'b0;
		end else begin
			// flash alternates all dots and stored character
			scan_char <= (at_cur && marker_flash && blink_ph) ? ALL_DOTS : dd_mem[scan_addr];
			scan_cursor <= at_cur && marker_shown;
		end
	end
endmodule : lcdi_device

// ==== lcdi_host.sv ====
// Controller end: Avalon-MM slave that polls the working flag, then moves
// one instruction or data byte over the link. Assumes lcdi_device on the far side.
`timescale 1ns/1ps
module lcdi_host (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	lcdi_bus_if.ctrl         bus,
	input  wire logic  [3:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	import lcdi_pkg::*;

	typedef enum {H_IDLE, H_POLL, H_XFER} lcdi_hstate_t;
	localparam int PH_END = E_CYC + GAP_CYC - 1;

	lcdi_hstate_t state;
	logic [2:0]   ph;
	logic         half, pend, rd_ack, wide, last_flag;
	logic [7:0]   cmd_byte, got, rdata;
	logic         cmd_rs, cmd_rd;

	// ------------------------------------------------------------------
	// Avalon slave
	// ------------------------------------------------------------------
	wire cmd_hit = avs_write && avs_address == REG_CMD;
	assign avs_waitrequest = (avs_read && !rd_ack) || (cmd_hit && pend);
	wire cmd_take = cmd_hit && !pend;

	// Read answer one cycle after the request
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd_ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			rd_ack <= avs_read && !rd_ack;
			if (avs_read && !rd_ack) begin
				if (avs_address == REG_CTRL) begin
					avs_readdata <= {31'h0, wide};
				end else if (avs_address == REG_STAT) begin
					avs_readdata <= {30'h0, last_flag, pend};
				end else if (avs_address == REG_RDATA) begin
					avs_readdata <= {24'h0, rdata};
				end else begin
					avs_readdata <= 32'h0;
				end
			end
		end
	end

	// Port width setting, must follow the function set sent
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wide <= CTL_WIDE_RST;
		end else if (avs_write && avs_address == REG_CTRL) begin
			wide <= avs_writedata[CTL_WIDE];
		end
	end

	// ------------------------------------------------------------------
	// Link engine
	// ------------------------------------------------------------------
	wire [7:0] cur_byte = (state == H_POLL) ? 8'h00 : cmd_byte;
	wire cur_rd = (state == H_POLL) ? 1'b1 : cmd_rd;
	assign bus.enable = (state != H_IDLE) && ph < 3'(E_CYC);
	assign bus.register_select = (state == H_XFER) && cmd_rs;
	assign bus.read_not_write = (state == H_IDLE) || cur_rd;
	assign bus.host_data_oe_n = (state == H_IDLE) || cur_rd;
	// high nibble first on the upper lines
	assign bus.host_data = wide ? cur_byte :
		(half ? {cur_byte[3:0], 4'h0} : {cur_byte[7:4], 4'h0});

	wire samp = (state != H_IDLE) && ph == 3'(E_CYC - 1);
	wire unit_end = (state != H_IDLE) && ph == 3'(PH_END);
	wire byte_end = unit_end && (wide || half);
	wire [7:0] got_now = wide ? got : {got[7:4], got[3:0]};

	// Capture read lines, pairing nibbles high then low
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			got <= 8'h00;
		end else if (samp) begin
			if (wide) begin
				got <= bus.data_bus;
			end else if (half) begin
				got[3:0] <= bus.data_bus[7:4];
			end else begin
				got[7:4] <= bus.data_bus[7:4];
			end
		end
	end

	// Sequencer: poll flag until clear, then transfer
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= H_IDLE;
			ph <= 3'h0;
			half <= 1'b0;
			pend <= 1'b0;
			cmd_byte <= 8'h00;
			cmd_rs <= 1'b0;
			cmd_rd <= 1'b0;
			rdata <= 8'h00;
			last_flag <= 1'b0;
		end else begin
			ph <= (state == H_IDLE || unit_end) ? 3'h0 : ph + 3'h1;
			if (unit_end) begin
				half <= ~wide & ~half;
			end
			case (state)
				H_IDLE: begin
					if (cmd_take) begin
						cmd_byte <= avs_writedata[7:0];
						cmd_rs <= avs_writedata[CMD_RS];
						cmd_rd <= avs_writedata[CMD_RD];
						pend <= 1'b1;
						state <= H_POLL;
					end
				end
				H_POLL: begin
					// wait for the flag to drop
					if (byte_end) begin
						last_flag <= got_now[7];
						state <= got_now[7] ? H_POLL : H_XFER;
					end
				end
				default: begin
					if (byte_end) begin
						if (cmd_rd) begin
							rdata <= got_now;
						end
						pend <= 1'b0;
						state <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule : lcdi_host

// ==== lcdi_props.sv ====
// Concurrent checks on the parallel link between the controller and display ends.
// Assumes one mclk domain; the signals come straight from lcdi_bus_if.
`timescale 1ns/1ps
module lcdi_props
	import lcdi_pkg::*;
#(
	parameter int LONG_CYC = lcdi_pkg::LONG_CYC
) (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       register_select,
	input wire logic       read_not_write,
	input wire logic       enable,
	input wire logic [7:0] host_data,
	input wire logic       host_data_oe_n,
	input wire logic       dev_data_oe_n
);
	// ------------------------------------------------------------------
	// Helper logic: cycles since the first unit of the last instruction or data byte
	// ------------------------------------------------------------------
	localparam int MIN_SHORT = SHORT_CYC - 1;
	localparam int MIN_LONG  = LONG_CYC - 1;
	logic        en_d;
	logic        op_start;
	logic        op_first;
	logic        was_long;
	logic [15:0] gap;

	// Status reads are always allowed, so they do not restart the count
	assign op_start = enable && !en_d && !(read_not_write && !register_select);
	// Second nibble of a 4-bit pair follows its first unit by exactly one unit
	assign op_first = op_start && gap != 16'h0003;

	// Enable history and gap counter, saturating so an idle link never wraps
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			en_d     <= 1'b0;
			gap      <= 16'hFFFF;
			was_long <= 1'b0;
		end else begin
			en_d <= enable;
			if (op_first) begin
				gap      <= 16'h0000;
				was_long <= !register_select && !read_not_write && host_data[7:2] == 6'h00
					&& host_data[1:0] != 2'h0;
			end else if (gap != 16'hFFFF) begin
				gap <= gap + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_OE_DEV: assert property (dev_data_oe_n == !(enable && read_not_write))
		else $error("device drive does not follow enable and read");
	AST_NO_CLASH: assert property (host_data_oe_n || dev_data_oe_n)
		else $error("both ends drive the data wire");
	AST_UNIT_LEN: assert property ($rose(enable) |=> enable ##1 !enable [*2])
		else $error("transfer unit is not two high and two low cycles");
	AST_HOLD: assert property ($rose(enable) |=> $stable(register_select)
		&& $stable(read_not_write) && $stable(host_data)) else $error("unit changed while enabled");
	AST_WR_DRIVE: assert property (enable && !read_not_write |-> !host_data_oe_n)
		else $error("host does not drive write data");
	AST_RD_RELEASE: assert property (enable && read_not_write |-> host_data_oe_n)
		else $error("host drives during a read");
	AST_BUSY_GAP: assert property (op_first |-> int'(gap) >= MIN_SHORT)
		else $error("unit issued while device still working");
	AST_LONG_GAP: assert property (op_first && was_long |-> int'(gap) >= MIN_LONG)
		else $error("unit issued during clear or home");

	// Main traffic kinds
	cover property ($rose(enable) && read_not_write && !register_select);
	cover property ($rose(enable) && !read_not_write && register_select);
	cover property ($rose(enable) && read_not_write && register_select);
endmodule : lcdi_props

// ==== testbench.sv ====
// Top bench: host and device ends joined by lcdi_bus_if, driven over Avalon-MM.
// Assumes the design's register map and a shortened long working time.
`timescale 1ns/1ps
module testbench;
	import lcdi_pkg::*;
	localparam int LONG = 300;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scan_row = 1'b0;
	logic [6:0]  scan_col = 7'h00;
	logic [7:0]  scan_char;
	logic        scan_cursor;
	logic        tall_font;
	logic        alt_pin = 1'b0;
	logic [1:0]  bias_sel = 2'b00;
	int          dots;
	logic        picture_on;
	logic        two_row;
	logic        bias_quarter;
	logic [31:0] q;
	int          fail_count = 0;
	int          num_checks = 0;

	lcdi_bus_if bus ();
	lcdi_host lcdi_host_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	lcdi_device #(.LONG_CYC(LONG), .BLINK_CYC(8)) lcdi_device_inst (.mclk(mclk), .rst_b(rst_b),
		.bus(bus), .alternate_set_pin(alt_pin), .bias_source_sel_1(bias_sel[1]),
		.bias_source_sel_2(bias_sel[0]), .scan_row(scan_row), .scan_col(scan_col),
		.scan_char(scan_char), .scan_cursor(scan_cursor), .picture_on(picture_on),
		.tall_font(tall_font), .two_row(two_row), .bias_quarter(bias_quarter));
	lcdi_props #(.LONG_CYC(LONG)) lcdi_props_inst (.mclk(mclk), .rst_b(rst_b),
		.register_select(bus.register_select), .read_not_write(bus.read_not_write),
		.enable(bus.enable), .host_data(bus.host_data), .host_data_oe_n(bus.host_data_oe_n),
		.dev_data_oe_n(bus.dev_data_oe_n));

	// 10 MHz clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One Avalon cycle, held until waitrequest is seen low at a rising edge
	task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= rd;
		avs_write     <= !rd;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 20000) begin
			fail_count++;
			complete_run();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : av

	// Queue one link byte, then poll until the engine is idle
	task automatic op(input logic rs, input logic rd, input logic [7:0] b);
		int n;
		n = 0;
		av(1'b0, REG_CMD, {22'h0, rd, rs, b});
		av(1'b1, REG_STAT, 32'h0);
		while (q[0] !== 1'b0 && n < 5000) begin
			av(1'b1, REG_STAT, 32'h0);
			n++;
		end
		if (n >= 5000) begin
			fail_count++;
			complete_run();
		end
	endtask : op

	task automatic rdd(input logic rs, input logic [7:0] exp);
		op(rs, 1'b1, 8'h00);
		av(1'b1, REG_RDATA, 32'h0);
		check(q[7:0], exp);
	endtask : rdd

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		check(8'(picture_on), 8'h00);
		av(1'b1, REG_CTRL, 32'h0);
		check(q[7:0], 8'h01);
		av(1'b0, 4'h2, 32'hFFFF_FFFF);
		av(1'b1, 4'h2, 32'h0);
		check(q[7:0], 8'h00);
		op(0, 0, 8'h01);
		rdd(0, 8'h00);
		op(0, 0, 8'h38);
		check(8'(two_row), 8'h01);
		op(0, 0, 8'h85);
		op(1, 0, 8'h41);
		op(1, 0, 8'h42);
		rdd(0, 8'h07);
		op(0, 0, 8'h85);
		rdd(1, 8'h41);
		rdd(1, 8'h42);
		op(0, 0, 8'h10);
		rdd(0, 8'h06);
		op(0, 0, 8'h14);
		rdd(0, 8'h07);
		op(0, 0, 8'h18);
		rdd(0, 8'h07);
		op(0, 0, 8'h04);
		op(1, 0, 8'h43);
		rdd(0, 8'h06);
		op(0, 0, 8'h06);
		op(0, 0, 8'hA7);
		op(1, 0, 8'h44);
		rdd(0, 8'h40);
		op(0, 0, 8'h02);
		rdd(0, 8'h00);
		op(0, 0, 8'h0C);
		check(8'(picture_on), 8'h01);
		scan_col <= 7'h05;
		repeat (2) @(posedge mclk);
		check(scan_char, 8'h41);
		op(0, 0, 8'h0F);
		scan_col <= 7'h00;
		dots = 0;
		repeat (20) begin
			@(posedge mclk);
			dots += int'(scan_char == ALL_DOTS);
		end
		check(8'(dots > 0 && dots < 20), 8'h01);
		check(8'(scan_cursor), 8'h01);
		op(0, 0, 8'h07);
		op(1, 0, 8'h20);
		scan_col <= 7'h04;
		repeat (2) @(posedge mclk);
		check(scan_char, 8'h41);
		check(8'(scan_cursor), 8'h00);
		op(0, 0, 8'h06);
		op(0, 0, 8'h08);
		check(8'(picture_on), 8'h00);
		op(0, 0, 8'h85);
		rdd(1, 8'h41);
		op(0, 0, 8'h42);
		op(1, 0, 8'h1F);
		rdd(0, 8'h03);
		op(0, 0, 8'h42);
		rdd(1, 8'h1F);
		op(0, 0, 8'h39);
		op(0, 0, 8'h1C);
		check(8'(bias_quarter), 8'h01);
		bias_sel <= 2'b11;
		repeat (4) @(posedge mclk);
		check(8'(bias_quarter), 8'h00);
		bias_sel <= 2'b00;
		op(0, 0, 8'h14);
		check(8'(bias_quarter), 8'h00);
		op(0, 0, 8'h4F);
		rdd(0, 8'h0F);
		op(0, 0, 8'h35);
		check(8'(tall_font), 8'h01);
		alt_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		check(8'(tall_font), 8'h00);
		complete_run();
	end
endmodule : testbench
